// File: hw/flash_cfg_loader.sv
`timescale 1ns/10ps
module flash_cfg_loader
  import flash_guard_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                srst,
  output logic                     rd_req,
  output logic [ARRAY_AW-1:0]      rd_addr,
  input  wire logic [31:0]         rd_data,
  input  wire logic                rd_valid,
  output logic                     ld_we,
  output load_state_t              ld_sel,
  output logic [31:0]              ld_data,
  output logic                     ld_done
);

  loader_state_t s_ff;
  loader_state_t nxt_s;

  always_comb begin
    nxt_s    = s_ff;
    nxt_s.we = 1'b0;
    unique case (s_ff.st)
      LD_SECTOR_PROTECT_BITS, LD_SUPERVISOR_ONLY_BITS, LD_SEC: begin
        nxt_s.req = 1'b1;
        unique case (s_ff.st)
          LD_SECTOR_PROTECT_BITS: nxt_s.addr = CFG_PROTECT_OFF;
          LD_SUPERVISOR_ONLY_BITS: nxt_s.addr = CFG_SUPERVISOR_ONLY_BITS_OFF;
          default: nxt_s.addr = CFG_SECURITY_OFF;
        endcase
        if (s_ff.req && rd_valid) begin
          nxt_s.req  = 1'b0;
          nxt_s.we   = 1'b1;
          nxt_s.sel  = s_ff.st;
          nxt_s.data = rd_data;
          unique case (s_ff.st)
            LD_SECTOR_PROTECT_BITS: nxt_s.st = LD_SUPERVISOR_ONLY_BITS;
            LD_SUPERVISOR_ONLY_BITS: nxt_s.st = LD_SEC;
            default: begin
              nxt_s.st   = LD_DONE;
              nxt_s.done = 1'b1;
            end
          endcase
        end
      end
      LD_DONE: begin
        nxt_s.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_req  = s_ff.req;
  assign rd_addr = s_ff.addr;
  assign ld_we   = s_ff.we;
  assign ld_sel  = s_ff.sel;
  assign ld_data = s_ff.data;
  assign ld_done = s_ff.done;

endmodule

// File: hw/flash_sector_guard.sv
`timescale 1ns/10ps
// Operation
// - Security register bit 31 enables the back-door key path.
// - Security register bit 30 reads one while flash is secured.
// - Flash is secured only when the code field equals 0x4AC8.
// - Security bits load at reset from array longword 0x0414.
// - Secured flash blocks all background debug traffic.
// - Secured flash boots single-chip, ignoring external reset config.
// - Protection mask loads at reset from array longword 0x0400.
// - Protection mask always readable; writable only while unlocked.
// - Protect bit one refuses program/erase of its sector.
// - 512 KB array forms thirty-two 16 KB sectors, one bit each.
// - Supervisor mask loads at reset from array longword 0x040C.
// - Supervisor mask always readable; writable only while unlocked.
// - Supervisor mask uses the protection mask's bit-to-sector mapping.
// - Supervisor bit one: user access ends in transfer error.
// - Supervisor bit zero: user and supervisor accesses allowed.
// - Lock bit readable, set once; while set masks reject writes.
// - Key-access bit writable only while back-door enable is one.
// - User-mode register access has no effect, ends in error.
module flash_sector_guard
  import flash_guard_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [APB_AW-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  input  wire logic [2:0]          pprot,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  output logic                     cfg_rd_req,
  output logic [ARRAY_AW-1:0]      cfg_rd_addr,
  input  wire logic [31:0]         cfg_rd_data,
  input  wire logic                cfg_rd_valid,
  input  wire flash_acc_t          flash_acc,
  output acc_resp_t                flash_resp,
  input  wire logic                dbg_req_pin,
  output logic                     dbg_req_out,
  output logic                     dbg_port_enable,
  input  wire logic                boot_cfg_en_pin,
  input  wire logic [1:0]          boot_cfg_pin,
  output logic [1:0]               boot_mode,
  output logic                     security_active_status,
  output logic                     backdoor_enable,
  output logic                     key_write_enable,
  output logic                     config_loaded
);

  guard_state_t s_ff;
  guard_state_t nxt_s;

  logic                ld_we;
  load_state_t         ld_sel;
  logic [31:0]         ld_data;
  logic                ld_done;
  logic [4:0]          sector;
  logic                complete;
  logic                bad_access;

  flash_cfg_loader u_loader (
    .core_clk (core_clk),
    .srst     (srst),
    .rd_req   (cfg_rd_req),
    .rd_addr  (cfg_rd_addr),
    .rd_data  (cfg_rd_data),
    .rd_valid (cfg_rd_valid),
    .ld_we    (ld_we),
    .ld_sel   (ld_sel),
    .ld_data  (ld_data),
    .ld_done  (ld_done)
  );

  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    reg_hit = (a == OFF_MODULE_CONFIG) || (a == OFF_SECURITY) ||
              (a == OFF_PROTECT) || (a == OFF_SUPERVISOR_ONLY_BITS);
  endfunction

  // Byte-lane merge for the two mask registers
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge_strb = r;
  endfunction

  function automatic logic [31:0] read_mux(input logic [APB_AW-1:0] a,
                                           input guard_state_t st);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFF_MODULE_CONFIG: begin
        r[LOCK_BIT]    = st.lock;
        r[KEY_ACC_BIT] = st.key_acc;
      end
      OFF_SECURITY: begin
        r[BACKDOOR_BIT]       = st.backdoor;
        r[SEC_STAT_BIT]       = st.sec_stat;
        r[SEC_CODE_MSB:0]     = st.sec_code;
      end
      OFF_PROTECT: r = st.protect;
      OFF_SUPERVISOR_ONLY_BITS:    r = st.supervisor_only_bits;
      default:     r = 32'h0000_0000;
    endcase
    read_mux = r;
  endfunction

  // Sector of the current array access
  assign sector   = flash_acc.addr[SECTOR_MSB:SECTOR_LSB];
  assign complete = psel && penable && s_ff.pready;
  assign bad_access = !reg_hit(paddr) || !pprot[0];

  always_comb begin
    nxt_s = s_ff;

    // Two-stage synchronisers for pins
    nxt_s.dbg_meta    = dbg_req_pin;
    nxt_s.dbg_sync    = s_ff.dbg_meta;
    nxt_s.cfg_en_meta = boot_cfg_en_pin;
    nxt_s.cfg_en_sync = s_ff.cfg_en_meta;
    nxt_s.boot_meta   = boot_cfg_pin;
    nxt_s.boot_sync   = s_ff.boot_meta;

    // Reset-time load of the configuration longwords
    if (ld_we) begin
      unique case (ld_sel)
        LD_SECTOR_PROTECT_BITS: nxt_s.protect = ld_data;
        LD_SUPERVISOR_ONLY_BITS: nxt_s.supervisor_only_bits    = ld_data;
        LD_SEC: begin
          nxt_s.backdoor = ld_data[BACKDOOR_BIT];
          nxt_s.sec_code = ld_data[SEC_CODE_MSB:0];
          nxt_s.sec_stat = (ld_data[SEC_CODE_MSB:0] ==
                            SECURE_CODE);
        end
        default: nxt_s.sec_stat = s_ff.sec_stat;
      endcase
    end
    nxt_s.loaded = ld_done;

    // APB slave: one wait-free access phase once loaded
    if (complete) begin
      nxt_s.pready = 1'b0;
      if (pwrite && !s_ff.pslverr) begin
        unique case (paddr)
          OFF_MODULE_CONFIG: begin
            if (pstrb[1] && pwdata[LOCK_BIT]) begin
              nxt_s.lock = 1'b1;
            end
            if (pstrb[0] && s_ff.backdoor) begin
              nxt_s.key_acc = pwdata[KEY_ACC_BIT];
            end
          end
          OFF_PROTECT: begin
            if (!s_ff.lock) begin
              nxt_s.protect = merge_strb(s_ff.protect, pwdata,
                                         pstrb);
            end
          end
          OFF_SUPERVISOR_ONLY_BITS: begin
            if (!s_ff.lock) begin
              nxt_s.supervisor_only_bits = merge_strb(s_ff.supervisor_only_bits, pwdata,
                                      pstrb);
            end
          end
          default: nxt_s.lock = s_ff.lock;
        endcase
      end
    end else if (psel && !s_ff.pready && s_ff.loaded) begin
      nxt_s.pready  = 1'b1;
      nxt_s.pslverr = bad_access;
      nxt_s.prdata  = (bad_access || pwrite) ? 32'h0000_0000 :
                      read_mux(paddr, s_ff);
    end

    // Array access checks, one cycle after the request
    nxt_s.resp.done       = flash_acc.valid;
    nxt_s.resp.xfer_err   = flash_acc.valid && flash_acc.user &&
                            s_ff.supervisor_only_bits[sector];
    nxt_s.resp.pe_refused = flash_acc.valid && flash_acc.prog_erase &&
                            s_ff.protect[sector];

    // Debug port and boot mode gating
    nxt_s.dbg_en  = s_ff.loaded && !s_ff.sec_stat;
    nxt_s.dbg_req = s_ff.loaded && !s_ff.sec_stat &&
                    s_ff.dbg_sync;
    if (!s_ff.loaded || s_ff.sec_stat || !s_ff.cfg_en_sync) begin
      nxt_s.boot_mode = BOOT_SINGLE_CHIP;
    end else begin
      nxt_s.boot_mode = s_ff.boot_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_ff <= GUARD_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pready                 = s_ff.pready;
  assign prdata                 = s_ff.prdata;
  assign pslverr                = s_ff.pslverr;
  assign flash_resp             = s_ff.resp;
  assign dbg_req_out            = s_ff.dbg_req;
  assign dbg_port_enable        = s_ff.dbg_en;
  assign boot_mode              = s_ff.boot_mode;
  assign security_active_status = s_ff.sec_stat;
  assign backdoor_enable        = s_ff.backdoor;
  assign key_write_enable       = s_ff.key_acc;
  assign config_loaded          = s_ff.loaded;

endmodule

// File: include/flash_guard_pkg.sv
package flash_guard_pkg;

  // Register bus and flash array geometry
  localparam int unsigned APB_AW       = 12;
  localparam int unsigned ARRAY_AW     = 19;
  localparam int unsigned SECTOR_COUNT = 32;
  localparam int unsigned SECTOR_LSB   = 14;
  localparam int unsigned SECTOR_MSB   = 18;

  // Register byte offsets on the APB
  localparam logic [APB_AW-1:0] OFF_MODULE_CONFIG = 12'h000;
  localparam logic [APB_AW-1:0] OFF_SECURITY      = 12'h008;
  localparam logic [APB_AW-1:0] OFF_PROTECT       = 12'h010;
  localparam logic [APB_AW-1:0] OFF_SUPERVISOR_ONLY_BITS          = 12'h014;

  // Configuration longwords inside the flash array
  localparam logic [ARRAY_AW-1:0] CFG_PROTECT_OFF  = 19'h00400;
  localparam logic [ARRAY_AW-1:0] CFG_SUPERVISOR_ONLY_BITS_OFF     = 19'h0040c;
  localparam logic [ARRAY_AW-1:0] CFG_SECURITY_OFF = 19'h00414;

  // Field positions
  localparam int unsigned LOCK_BIT      = 10;
  localparam int unsigned KEY_ACC_BIT   = 5;
  localparam int unsigned BACKDOOR_BIT  = 31;
  localparam int unsigned SEC_STAT_BIT  = 30;
  localparam int unsigned SEC_CODE_MSB  = 15;

  // Values
  localparam logic [15:0] SECURE_CODE      = 16'h4ac8;
  localparam logic [31:0] PROTECT_RST      = 32'hffff_ffff;
  localparam logic [31:0] SUPERVISOR_ONLY_BITS_RST         = 32'hffff_ffff;
  localparam logic [1:0]  BOOT_SINGLE_CHIP = 2'h0;

  typedef enum logic [1:0] {
    LD_SECTOR_PROTECT_BITS = 2'b00,
    LD_SUPERVISOR_ONLY_BITS = 2'b01,
    LD_SEC  = 2'b10,
    LD_DONE = 2'b11
  } load_state_t;

  typedef struct packed {
    logic                valid;
    logic                user;
    logic                prog_erase;
    logic [ARRAY_AW-1:0] addr;
  } flash_acc_t;

  typedef struct packed {
    logic done;
    logic xfer_err;
    logic pe_refused;
  } acc_resp_t;

  typedef struct packed {
    load_state_t         st;
    logic                req;
    logic [ARRAY_AW-1:0] addr;
    logic                we;
    load_state_t         sel;
    logic [31:0]         data;
    logic                done;
  } loader_state_t;

  typedef struct packed {
    logic        dbg_meta;
    logic        dbg_sync;
    logic        cfg_en_meta;
    logic        cfg_en_sync;
    logic [1:0]  boot_meta;
    logic [1:0]  boot_sync;
    logic        loaded;
    logic [31:0] protect;
    logic [31:0] supervisor_only_bits;
    logic        backdoor;
    logic [15:0] sec_code;
    logic        sec_stat;
    logic        lock;
    logic        key_acc;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    acc_resp_t   resp;
    logic        dbg_en;
    logic        dbg_req;
    logic [1:0]  boot_mode;
  } guard_state_t;

  localparam guard_state_t GUARD_RST = '{
    protect: PROTECT_RST,
    supervisor_only_bits:    SUPERVISOR_ONLY_BITS_RST,
    default: '0
  };

endpackage

// File: sim/cfg_array_model.sv
`timescale 1ns/10ps
module cfg_array_model
  import flash_guard_pkg::*;
#(
  parameter logic [31:0] SECTOR_PROTECT_BITS_W = 32'h0000_00f0,
  parameter logic [31:0] SUPERVISOR_ONLY_BITS_W = 32'h0000_0f00
)(
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                cfg_rd_req,
  input  wire logic [ARRAY_AW-1:0] cfg_rd_addr,
  input  wire logic [31:0]         sec_word,
  output logic [31:0]              cfg_rd_data,
  output logic                     cfg_rd_valid
);
  int dly = 0;
  initial cfg_rd_data = 32'h0;
  initial cfg_rd_valid = 1'b0;
  // Idle data toggles so a stale word is never mistaken for an answer
  always @(posedge core_clk) begin
    if (srst || !cfg_rd_req || cfg_rd_valid) begin
      cfg_rd_valid <= 1'b0;
      cfg_rd_data  <= ~cfg_rd_data;
      dly          <= 0;
    end else if (dly < (cfg_rd_addr[2] ? 2 : 0)) begin
      dly <= dly + 1;
    end else begin
      cfg_rd_valid <= 1'b1;
      case (cfg_rd_addr)
        CFG_PROTECT_OFF: cfg_rd_data <= SECTOR_PROTECT_BITS_W;
        CFG_SUPERVISOR_ONLY_BITS_OFF:    cfg_rd_data <= SUPERVISOR_ONLY_BITS_W;
        default:         cfg_rd_data <= sec_word;
      endcase
    end
  end
endmodule

// File: sim/flash_sector_guard_properties.sv
`timescale 1ns/10ps
module flash_sector_guard_properties
  import flash_guard_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                srst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [APB_AW-1:0]   paddr,
  input wire logic [2:0]          pprot,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic                cfg_rd_req,
  input wire logic [ARRAY_AW-1:0] cfg_rd_addr,
  input wire flash_acc_t          flash_acc,
  input wire acc_resp_t           flash_resp,
  input wire logic                dbg_port_enable,
  input wire logic                dbg_req_out,
  input wire logic [1:0]          boot_mode,
  input wire logic                security_active_status,
  input wire logic                backdoor_enable,
  input wire logic                key_write_enable,
  input wire logic                config_loaded
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic hit;
  logic mapped;
  assign hit    = psel && penable && pready;
  assign mapped = paddr inside {OFF_MODULE_CONFIG, OFF_SECURITY,
                                OFF_PROTECT, OFF_SUPERVISOR_ONLY_BITS};

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_held_load: assert property (!config_loaded |-> !pready)
    else $error("answer before configuration loaded");
  a_user_refused: assert property (
    hit && !pprot[0] |-> pslverr && prdata == '0)
    else $error("user access not refused");
  a_unmapped_err: assert property (hit && pprot[0] && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_resp_next: assert property (flash_acc.valid |=> flash_resp.done)
    else $error("array check gave no answer");
  a_super_no_err: assert property (
    flash_acc.valid && !flash_acc.user |=> !flash_resp.xfer_err)
    else $error("supervisor access got transfer error");
  a_secure_debug: assert property (
    security_active_status |-> !dbg_port_enable && !dbg_req_out)
    else $error("debug open while secured");
  a_secure_boot: assert property (
    security_active_status |-> boot_mode == BOOT_SINGLE_CHIP)
    else $error("secured part not in single chip boot");
  a_key_door: assert property (
    $rose(key_write_enable) |-> backdoor_enable)
    else $error("key access set without back door");
  a_first_fetch: assert property (
    $fell(srst) |-> ##[1:2] (cfg_rd_req && cfg_rd_addr == CFG_PROTECT_OFF))
    else $error("first config fetch wrong");
endmodule

bind flash_sector_guard flash_sector_guard_properties u_props (.*);

// File: sim/flash_sector_guard_tb.sv
`timescale 1ns/10ps
module flash_sector_guard_tb;
  import flash_guard_pkg::*;
  localparam logic [31:0] SECTOR_PROTECT_BITS_V = 32'h0000_00f0;
  localparam logic [31:0] SUPERVISOR_ONLY_BITS_V = 32'h0000_0f00;
  logic                core_clk = 1'b0;
  logic                srst, psel, penable, pwrite;
  logic [APB_AW-1:0]   paddr;
  logic [31:0]         pwdata, prdata, cfg_rd_data, sec_word;
  logic [31:0]         rdat, sector_protect_bits_m, supervisor_only_bits_m;
  logic [3:0]          pstrb;
  logic [2:0]          pprot;
  logic                pready, pslverr, rerr, cfg_rd_req, cfg_rd_valid;
  logic [ARRAY_AW-1:0] cfg_rd_addr;
  flash_acc_t          flash_acc;
  acc_resp_t           flash_resp;
  logic                dbg_req_pin, dbg_req_out, dbg_port_enable;
  logic                boot_cfg_en_pin, security_active_status;
  logic [1:0]          boot_cfg_pin, boot_mode;
  logic                backdoor_enable, key_write_enable, config_loaded;
  int                  n_errors = 0;
  int                  samples_checked = 0;

  flash_sector_guard DUT (.*);
  cfg_array_model #(.SECTOR_PROTECT_BITS_W(SECTOR_PROTECT_BITS_V), .SUPERVISOR_ONLY_BITS_W(SUPERVISOR_ONLY_BITS_V)) u_array (.*);

  always #5 core_clk = ~core_clk;

  task automatic test_done;
    $display("%0d checks, %0d mismatches", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic sup);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pprot  <= {2'h0, sup};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      n_errors++;
      test_done;
    end
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b1);
    chk(rdat, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b1);
    chk({31'h0, rerr}, 32'h0);
  endtask

  task automatic wait_ld;
    int n;
    n = 0;
    while (config_loaded !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200) begin
      n_errors++;
      test_done;
    end
  endtask

  task automatic rst_ld(input logic [31:0] w);
    sec_word <= w;
    srst     <= 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    wait_ld;
    sector_protect_bits_m = SECTOR_PROTECT_BITS_V;
    supervisor_only_bits_m = SUPERVISOR_ONLY_BITS_V;
  endtask

  // One array access pulse, answer checked the cycle after
  task automatic probe(input logic u, input logic [ARRAY_AW-1:0] a,
                       input logic [2:0] e);
    flash_acc <= '{1'b1, u, 1'b1, a};
    @(posedge core_clk);
    flash_acc.valid <= 1'b0;
    @(posedge core_clk);
    chk({29'h0, flash_resp}, {29'h0, e});
  endtask

  // Both ends of every sector, odd sectors in user mode
  task automatic sweep;
    logic [2:0] e3;
    for (int s = 0; s < 32; s++) begin
      e3 = {1'b1, s[0] & supervisor_only_bits_m[s], sector_protect_bits_m[s]};
      probe(s[0], {s[4:0], 14'h0000}, e3);
      probe(s[0], {s[4:0], 14'h3fff}, e3);
    end
    $display("sector sweep done");
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    pprot = 3'h1;
    flash_acc = '0;
    dbg_req_pin = 1'b1;
    boot_cfg_en_pin = 1'b1;
    boot_cfg_pin = 2'h2;
    sec_word = 32'h8000_1234;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    wait_ld;
    sector_protect_bits_m = SECTOR_PROTECT_BITS_V;
    supervisor_only_bits_m = SUPERVISOR_ONLY_BITS_V;
    rd(OFF_PROTECT, SECTOR_PROTECT_BITS_V);
    rd(OFF_SUPERVISOR_ONLY_BITS, SUPERVISOR_ONLY_BITS_V);
    rd(OFF_SECURITY, 32'h8000_1234);
    chk(backdoor_enable, 32'h1);
    chk({dbg_port_enable, dbg_req_out}, 32'h3);
    chk(boot_mode, 32'h2);
    sweep;
    wr(OFF_PROTECT, 32'h8000_0001);
    wr(OFF_SUPERVISOR_ONLY_BITS, 32'h0000_0003);
    sector_protect_bits_m = 32'h8000_0001;
    supervisor_only_bits_m = 32'h0000_0003;
    rd(OFF_PROTECT, sector_protect_bits_m);
    rd(OFF_SUPERVISOR_ONLY_BITS, supervisor_only_bits_m);
    sweep;
    apb(1'b1, OFF_SUPERVISOR_ONLY_BITS, 32'hffff_ffff, 1'b0);
    chk({31'h0, rerr}, 32'h1);
    rd(OFF_SUPERVISOR_ONLY_BITS, supervisor_only_bits_m);
    apb(1'b0, 12'h00c, 32'h0, 1'b1);
    chk({31'h0, rerr}, 32'h1);
    wr(OFF_SECURITY, 32'h0);
    rd(OFF_SECURITY, 32'h8000_1234);
    wr(OFF_MODULE_CONFIG, 32'h0000_0020);
    rd(OFF_MODULE_CONFIG, 32'h0000_0020);
    chk(key_write_enable, 32'h1);
    wr(OFF_MODULE_CONFIG, 32'h0000_0420);
    wr(OFF_PROTECT, 32'h0);
    rd(OFF_PROTECT, sector_protect_bits_m);
    wr(OFF_SUPERVISOR_ONLY_BITS, 32'h0);
    rd(OFF_SUPERVISOR_ONLY_BITS, supervisor_only_bits_m);
    wr(OFF_MODULE_CONFIG, 32'h0);
    rd(OFF_MODULE_CONFIG, 32'h0000_0400);
    $display("register test done");
    rst_ld(32'h0000_4ac8);
    rd(OFF_PROTECT, SECTOR_PROTECT_BITS_V);
    rd(OFF_SECURITY, 32'h4000_4ac8);
    chk(security_active_status, 32'h1);
    chk({dbg_port_enable, dbg_req_out}, 32'h0);
    chk(boot_mode, 32'h0);
    wr(OFF_MODULE_CONFIG, 32'h0000_0020);
    rd(OFF_MODULE_CONFIG, 32'h0);
    chk(key_write_enable, 32'h0);
    rst_ld(32'h0000_4ac9);
    rd(OFF_SECURITY, 32'h0000_4ac9);
    chk(security_active_status, 32'h0);
    $display("security test done");
    // Lane 0 write protects the configuration sector, then a full-word write lifts it again
    pstrb <= 4'h1;
    wr(OFF_PROTECT, 32'hffff_fff1);
    pstrb <= 4'hf;
    rd(OFF_PROTECT, 32'h0000_00f1);
    probe(1'b0, CFG_PROTECT_OFF, 3'b101);
    wr(OFF_PROTECT, 32'h0000_00f0);
    probe(1'b0, CFG_PROTECT_OFF, 3'b100);
    $display("protect update test done");
    test_done;
  end
endmodule
